// >>> asrp_defs.svh
`ifndef ASRP_DEFS_SVH
`define ASRP_DEFS_SVH
// word layout
`define ASRP_WORD_BITS 16
`define ASRP_LEAD_ZEROS 4
`define ASRP_RESULT_BITS 12
// index of the last bit slot, reached on the fifteenth serial clock fall; the sixteenth fall after select low ends the word
`define ASRP_LAST_BIT_IDX 4'hf
// least quiet time after a read, ns (kept by the controller)
`define ASRP_GAP_NS 60
// most time from select low to output driven, ns
`define ASRP_DRIVE_NS 20
`define ASRP_CLK_NS 8
`define ASRP_DRIVE_CYC ((`ASRP_DRIVE_NS) / (`ASRP_CLK_NS))
// most time from last falling edge to release, ns
`define ASRP_RELEASE_NS 35
`define ASRP_RELEASE_CYC ((`ASRP_RELEASE_NS) / (`ASRP_CLK_NS))
`endif

// >>> asrp_pkg.sv
package asrp_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} asrp_state_type;
endpackage : asrp_pkg

// >>> asrp_sar.sv
`timescale 1ns/100ps
`include "asrp_defs.svh"
// successive approximation engine: one decision per serial clock fall, for the first WIDTH falls after start
module asrp_sar
  import asrp_pkg::*;
#(
  parameter int WIDTH = `ASRP_RESULT_BITS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic step,
  // input level, twos complement, taken in at start
  input wire logic [WIDTH-1:0] sample_code,
  // result, twos complement
  output logic [WIDTH-1:0] result
);
  logic [WIDTH-1:0] trial_q, trial_d;
  logic [WIDTH-1:0] bit_q, bit_d;
  logic [WIDTH-1:0] held_q, held_d;

  // each step keeps or drops the trial bit, top bit first
  always_comb
  begin
    trial_d = trial_q;
    bit_d = bit_q;
    held_d = held_q;
    if (start)
    begin
      held_d = sample_code;
      bit_d = {1'b1, {(WIDTH-1){1'b0}}};
      trial_d = {1'b1, {(WIDTH-1){1'b0}}};
    end
    else if (step && bit_q != '0)
    begin
      // offset binary compare; sign bit flipped at the output
      if ((held_q ^ {1'b1, {(WIDTH-1){1'b0}}}) < trial_q)
        trial_d = trial_q & ~bit_q;
      trial_d = trial_d | (bit_q >> 1);
      bit_d = bit_q >> 1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      trial_q <= '0;
      bit_q <= '0;
      held_q <= '0;
    end
    else
    begin
      trial_q <= trial_d;
      bit_q <= bit_d;
      held_q <= held_d;
    end
  end

  // back to twos complement: negative inputs give a set top bit
  assign result = trial_q ^ {1'b1, {(WIDTH-1){1'b0}}};
endmodule : asrp_sar

// >>> asrp_port.sv
`timescale 1ns/100ps
`include "asrp_defs.svh"
module asrp_port
  import asrp_pkg::*;
#(
  parameter int RESULT_BITS = `ASRP_RESULT_BITS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins from the controller
  input wire logic frame_sel_n,
  input wire logic serial_clk,
  // converted input level, twos complement
  input wire logic [RESULT_BITS-1:0] sample_code,
  // serial result pin
  output logic serial_result_out,
  output logic serial_result_oe,
  // last captured word, for observation
  output logic [RESULT_BITS-1:0] last_result
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] sel_sync_q, sclk_sync_q;
  logic sel_n_s, sclk_s, sel_prev_q, sclk_prev_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sel_sync_q <= 2'h3;
      sclk_sync_q <= 2'h3;
      sel_prev_q <= 1'b1;
      sclk_prev_q <= 1'b1;
    end
    else
    begin
      sel_sync_q <= {sel_sync_q[0], frame_sel_n};
      sclk_sync_q <= {sclk_sync_q[0], serial_clk};
      sel_prev_q <= sel_sync_q[1];
      sclk_prev_q <= sclk_sync_q[1];
    end
  end
  assign sel_n_s = sel_sync_q[1];
  assign sclk_s = sclk_sync_q[1];

  logic sel_fall, sclk_fall;
  assign sel_fall = sel_prev_q && !sel_n_s;
  assign sclk_fall = sclk_prev_q && !sclk_s && !sel_n_s;

  ////////////////////////////////////////////////////////////////////////
  // conversion engine, stepped by serial clock falls only
  logic [RESULT_BITS-1:0] sar_result;
  asrp_sar #(
    .WIDTH(RESULT_BITS)
  ) u_sar (
    .clk(clk),
    .rstn(rstn),
    .start(sel_fall),
    .step(sclk_fall),
    .sample_code(sample_code),
    .result(sar_result)
  );

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer and shifter
  asrp_state_type state_q, state_d;
  logic [3:0] idx_q, idx_d;
  logic out_q, out_d, oe_q, oe_d;
  logic [RESULT_BITS-1:0] last_q, last_d;

  // bit slot n of the word: zeros first, then result msb first
  function automatic logic word_bit(input logic [3:0] n,
                                    input logic [RESULT_BITS-1:0] r);
    if (n < 4'(`ASRP_LEAD_ZEROS))
      word_bit = 1'b0;
    else
      word_bit = r[RESULT_BITS - 1 - (int'(n) - `ASRP_LEAD_ZEROS)];
  endfunction : word_bit

  // the sar decides result bit k (counted from the msb) on fall k+1, three falls before
  // it is shifted out on fall k+4; the lag trades latency for area
  logic [RESULT_BITS-1:0] trial_view;
  assign trial_view = sar_result;

  always_comb
  begin
    state_d = state_q;
    idx_d = idx_q;
    out_d = out_q;
    oe_d = oe_q;
    last_d = last_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (sel_fall)
        begin
          state_d = ST_SHIFT;
          idx_d = 4'h0;
          oe_d = 1'b1;
          out_d = 1'b0;
        end
      end
      ST_SHIFT:
      begin
        if (sel_n_s)
        begin
          state_d = ST_IDLE;
          oe_d = 1'b0;
        end
        else if (sclk_fall)
        begin
          if (idx_q == `ASRP_LAST_BIT_IDX)
          begin
            state_d = ST_DONE;
            oe_d = 1'b0;
            out_d = 1'b0;
            last_d = trial_view;
          end
          else
          begin
            idx_d = idx_q + 4'h1;
            out_d = word_bit(idx_q + 4'h1, trial_view);
          end
        end
      end
      ST_DONE:
      begin
        // wait for the controller to close the frame
        if (sel_n_s)
          state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      idx_q <= 4'h0;
      out_q <= 1'b0;
      oe_q <= 1'b0;
      last_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      idx_q <= idx_d;
      out_q <= out_d;
      oe_q <= oe_d;
      last_q <= last_d;
    end
  end

  assign serial_result_out = out_q;
  assign serial_result_oe = oe_q;
  assign last_result = last_q;

  ////////////////////////////////////////////////////////////////////////
  // level taken at select fall, kept only to judge the finished result;
  // held apart from the engine so a broken search cannot hide itself
  logic [RESULT_BITS-1:0] code_seen_q, code_seen_d;

  always_comb
  begin
    code_seen_d = code_seen_q;
    if (sel_fall)
      code_seen_d = sample_code;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      code_seen_q <= '0;
    else
      code_seen_q <= code_seen_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_DRIVE_ON_SELECT: assert property (@(posedge clk)
    disable iff (!rstn)
    sel_fall && state_q == ST_IDLE |=> serial_result_oe)
    else $error("output not driven after select");
  AST_FLOAT_WHEN_IDLE: assert property (@(posedge clk)
    disable iff (!rstn)
    state_q == ST_IDLE && !sel_fall |=> !serial_result_oe)
    else $error("output driven while deselected");
  AST_CLOSE_ON_DESELECT: assert property (@(posedge clk)
    disable iff (!rstn)
    serial_result_oe && sel_n_s |=> !serial_result_oe)
    else $error("output held after deselect");
  AST_LEAD_ZEROS: assert property (@(posedge clk)
    disable iff (!rstn)
    serial_result_oe && idx_q < 4'h4 |-> !serial_result_out)
    else $error("leading bit not zero");
  AST_CHANGE_ON_FALL: assert property (@(posedge clk)
    disable iff (!rstn)
    state_q == ST_SHIFT && !sclk_fall && !sel_n_s
    |=> $stable(idx_q) && $stable(serial_result_out))
    else $error("bit moved without a falling edge");
  AST_RELEASE: assert property (@(posedge clk)
    disable iff (!rstn)
    state_q == ST_SHIFT && !sel_n_s && sclk_fall && idx_q == 4'hf
    |=> !serial_result_oe && state_q == ST_DONE)
    else $error("output not released after last bit");
  AST_MSB_SLOT: assert property (@(posedge clk)
    disable iff (!rstn)
    state_q == ST_SHIFT && !sel_n_s && sclk_fall && idx_q == 4'h3
    |=> serial_result_out == sar_result[RESULT_BITS-1])
    else $error("msb not in fifth slot");
  AST_ONE_START: assert property (@(posedge clk)
    disable iff (!rstn)
    sel_fall |=> state_q == ST_SHIFT && idx_q == 4'h0)
    else $error("select fall did not open a frame");
  AST_RANGE: assert property (@(posedge clk)
    disable iff (!rstn)
    state_q == ST_SHIFT && !sel_n_s && sclk_fall && idx_q == 4'hf
    |=> last_q == code_seen_q)
    else $error("finished result differs from sampled level");
endmodule : asrp_port

// >>> asrp_host_model.sv
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////
// host side: drives select and serial clock, collects the word
module asrp_host_model
(
  // clock
  input wire logic clk,
  // pins to the device
  output logic frame_sel_n,
  output logic serial_clk,
  // pins from the device
  input wire logic serial_result_out,
  input wire logic serial_result_oe
);
  // undriven line shows the opposite of the last level, so a late drive
  // or an early release reads as a wrong bit
  logic pin_level;
  assign pin_level = serial_result_oe ? serial_result_out : ~serial_result_out;

  // idle: deselected, clock parked high between frames
  initial
  begin
    frame_sel_n = 1'b1;
    serial_clk = 1'b1;
  end

  // one frame; each bit sampled half a clock before the next fall
  task automatic read_word(input int falls, output logic [15:0] w,
                           output logic oe_on, output logic oe_end);
    int k;
    w = 16'h0000;
    @(posedge clk) frame_sel_n <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk) w[15] = pin_level;
    oe_on = serial_result_oe;
    for (k = 1; k <= falls; k++)
    begin
      @(posedge clk) serial_clk <= 1'b0;
      repeat (4) @(posedge clk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk) if (k < 16) w[15-k] = pin_level;
    end
    oe_end = serial_result_oe;
    @(posedge clk) frame_sel_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : read_word

  // clock pulses while deselected, which must be ignored
  task automatic stray_clocks(input int n);
    repeat (n)
    begin
      @(posedge clk) serial_clk <= 1'b0;
      repeat (4) @(posedge clk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge clk);
    end
  endtask : stray_clocks
endmodule : asrp_host_model

// >>> tb_adc_serial_result_port.sv
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////
module tb_adc_serial_result_port;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] sample_code = 12'h000;
  logic frame_sel_n;
  logic serial_clk;
  logic serial_result_out;
  logic serial_result_oe;
  logic [11:0] last_result;
  int n_mismatch = 0;
  int compares = 0;

  // 125 MHz clock
  always #4 clk = ~clk;

  asrp_port DUT (.clk(clk), .rstn(rstn), .frame_sel_n(frame_sel_n),
    .serial_clk(serial_clk), .sample_code(sample_code),
    .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .last_result(last_result));

  asrp_host_model host (.clk(clk), .frame_sel_n(frame_sel_n),
    .serial_clk(serial_clk), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe));

  //////////////////////////////////////////////////////////////////////
  // comparison and verdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results;
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // code set up an edge before select falls, held through the frame
  task automatic frame(input logic [11:0] code, input int falls,
                       input logic oe_end_exp);
    logic [15:0] w;
    logic oe_on;
    logic oe_end;
    @(posedge clk) sample_code <= code;
    host.read_word(falls, w, oe_on, oe_end);
    chk({15'h0000, oe_on}, 16'h0001);
    if (falls >= 16)
      chk(w, {4'h0, code});
    chk({15'h0000, oe_end}, {15'h0000, oe_end_exp});
    @(negedge clk) chk({15'h0000, serial_result_oe}, 16'h0000);
  endtask : frame

  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_idle;
    @(negedge clk) chk({15'h0000, serial_result_oe}, 16'h0000);
    host.stray_clocks(3);
    @(negedge clk) chk({15'h0000, serial_result_oe}, 16'h0000);
    chk({4'h0, last_result}, 16'h0000);
  endtask : t_idle

  // extreme codes, the zero boundary, and a mixed pattern
  task automatic t_codes;
    logic [11:0] codes [5];
    codes = '{12'h800, 12'h7ff, 12'h000, 12'hfff, 12'h5a3};
    foreach (codes[i])
    begin
      frame(codes[i], 16, 1'b0);
      chk({4'h0, last_result}, {4'h0, codes[i]});
    end
  endtask : t_codes

  // frame closed early: no result kept, next frame converts afresh
  task automatic t_abort;
    frame(12'h123, 8, 1'b1);
    chk({4'h0, last_result}, 16'h05a3);
    frame(12'h9e1, 16, 1'b0);
    chk({4'h0, last_result}, 16'h09e1);
  endtask : t_abort

  // falls beyond the sixteenth leave the pin released
  task automatic t_extra;
    frame(12'h456, 18, 1'b0);
    chk({4'h0, last_result}, 16'h0456);
  endtask : t_extra

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_idle();
    t_codes();
    t_abort();
    t_extra();
    results();
  end

  // watchdog, well beyond the roughly 1300 cycles the tests need
  initial
  begin
    #200000;
    n_mismatch++;
    results();
  end
endmodule : tb_adc_serial_result_port
